// ### hw/power_sleep_mode_controller.sv
// Operating-mode controller: power-off, sleep entry, paging and wake-up.
// Assumes all inputs synchronous to clk; settings written over a plain
// register port; the rest of the modem acknowledges shutdown steps.
//
// Operation
// - Key held low 3 s starts power-off
// - Power-off disables interfaces and closes network together
// - Undervoltage powers down at once, silently
// - Reset command powers off like key
// - After reset start fully active idle
// - Nonzero seconds setting enables sleep; zero disables
// - No sleep while serial, network, task busy
// - Sleep freezes interface outputs, stops clocks
// - Asleep: serial disabled, CTS high
// - Paging wakeups drop CTS briefly
// - Blocking setting keeps CTS high during paging
// - Wake to idle holds CTS 15 ms
// - Wake input low keeps device idle
// - Network event wakes, alerts host by method
// - Serial traffic keeps device awake
// - Writing zero ends sleep immediately
// - CTS high disabled, low enabled
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "pwr_sleep_cfg.svh"

module power_sleep_mode_controller #(
  parameter int MS_CYCLES = `MS_CYCLES,
  parameter int KEY_OFF_MS = `KEY_OFF_S * `SEC_MS,
  parameter int SETTLE_MS = `SETTLE_MS,
  parameter int PAGE_PERIOD_MS = `PAGE_PERIOD_MS,
  parameter int PAGE_AWAKE_MS = `PAGE_AWAKE_MS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Pins
  input wire logic power_key_n,
  input wire logic wake_request_in_n,
  input wire logic supply_low,
  // Activity and events
  input wire pwr_sleep_pkg::activity_t activity,
  input wire logic net_event,
  input wire logic shutdown_done,
  // Register port
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Status outputs
  output logic cts_n_out,
  output logic host_wake_out,
  output logic ring_out,
  output logic serial_alert,
  output logic clocks_run,
  output logic freeze,
  output logic power_hold,
  output pwr_sleep_pkg::shutdown_t shutdown,
  output pwr_sleep_pkg::mode_t mode
);
  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [1:0] A_SECS = 2'h0;
  localparam logic [1:0] A_CFG = 2'h1;
  localparam logic [1:0] A_STAT = 2'h2;
  localparam logic [1:0] A_CMD = 2'h3;

  logic [7:0] inactivity_sleep_seconds;
  logic sleep_cts_block_setting;
  pwr_sleep_pkg::alert_t alert_sel;
  logic system_reset_command;
  logic secs_zero_wr;
  logic [31:0] ms_cnt;
  logic ms_tick;
  logic [15:0] key_ms;
  logic [9:0] sec_ms;
  logic [7:0] idle_secs;
  logic [15:0] phase_ms;
  logic [31:0] settle_cnt;
  logic busy;
  logic awake_req;
  logic event_pend;
  logic alert_now;

  assign busy = activity.serial_busy | activity.net_busy | activity.task_busy;
  assign awake_req = busy | ~wake_request_in_n | net_event;
  assign system_reset_command = wr && addr == A_CMD && wdata[0];
  assign secs_zero_wr = wr && addr == A_SECS && wdata == 8'h00;

  function automatic logic [31:0] ms_to_cycles(input int ms);
    ms_to_cycles = 32'(ms * MS_CYCLES);
  endfunction : ms_to_cycles

  // ----------------------------------------------------------------------
  // Register writes and reads
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      inactivity_sleep_seconds <= `SLEEP_SECS_RESET;
      sleep_cts_block_setting <= 1'b0;
      alert_sel <= pwr_sleep_pkg::alert_wake_out;
    end else if (wr && addr == A_SECS) begin
      inactivity_sleep_seconds <= wdata;
    end else if (wr && addr == A_CFG) begin
      sleep_cts_block_setting <= wdata[0];
      alert_sel <= pwr_sleep_pkg::alert_t'(wdata[2:1]);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        A_SECS: rdata <= inactivity_sleep_seconds;
        A_CFG: rdata <= {5'h00, alert_sel, sleep_cts_block_setting};
        A_STAT: rdata <= {4'h0, cts_n_out, mode};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Millisecond base
  // ----------------------------------------------------------------------
  // A millisecond enable keeps the long counters narrow, except settle_cnt, which counts cycles.
  always_ff @(posedge clk) begin
    if (!nrst || ms_cnt == 32'(MS_CYCLES - 1)) begin
      ms_cnt <= 32'h0;
    end else begin
      ms_cnt <= ms_cnt + 32'h1;
    end
  end
  assign ms_tick = ms_cnt == 32'(MS_CYCLES - 1);

  // Power key hold timer.
  always_ff @(posedge clk) begin
    if (!nrst || power_key_n) begin
      key_ms <= 16'h0;
    end else if (ms_tick && key_ms != 16'(KEY_OFF_MS)) begin
      key_ms <= key_ms + 16'h1;
    end
  end

  // Inactivity seconds, restarted by any activity.
  always_ff @(posedge clk) begin
    if (!nrst || awake_req || mode != pwr_sleep_pkg::st_idle) begin
      sec_ms <= 10'h0;
      idle_secs <= 8'h00;
    end else if (ms_tick) begin
      if (sec_ms == 10'(`SEC_MS - 1)) begin
        sec_ms <= 10'h0;
        if (idle_secs != 8'hFF) begin
          idle_secs <= idle_secs + 8'h01;
        end
      end else begin
        sec_ms <= sec_ms + 10'h1;
      end
    end
  end

  // Paging cycle timer, running in every mode but idle and settling.
  always_ff @(posedge clk) begin
    if (!nrst || mode == pwr_sleep_pkg::st_idle || mode == pwr_sleep_pkg::st_settle) begin
      phase_ms <= 16'h0;
    end else if (ms_tick) begin
      phase_ms <= (phase_ms == 16'(PAGE_PERIOD_MS - 1)) ? 16'h0 : phase_ms + 16'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Mode machine
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mode <= pwr_sleep_pkg::st_idle;
      settle_cnt <= 32'h0;
    end else if (supply_low) begin
      mode <= pwr_sleep_pkg::st_off;
    end else if ((key_ms == 16'(KEY_OFF_MS) || system_reset_command) &&
                 mode != pwr_sleep_pkg::st_off) begin
      mode <= pwr_sleep_pkg::st_power_off;
    end else begin
      case (mode)
        pwr_sleep_pkg::st_idle: begin
          if (!secs_zero_wr && inactivity_sleep_seconds != 8'h00 && !awake_req &&
              idle_secs >= inactivity_sleep_seconds) begin
            mode <= pwr_sleep_pkg::st_sleep;
          end
        end
        pwr_sleep_pkg::st_sleep, pwr_sleep_pkg::st_page: begin
          if (secs_zero_wr || awake_req) begin
            mode <= pwr_sleep_pkg::st_settle;
            settle_cnt <= ms_to_cycles(SETTLE_MS);
          end else if (phase_ms == 16'(PAGE_PERIOD_MS - PAGE_AWAKE_MS)) begin
            mode <= pwr_sleep_pkg::st_page;
          end else if (phase_ms == 16'h0) begin
            mode <= pwr_sleep_pkg::st_sleep;
          end
        end
        pwr_sleep_pkg::st_settle: begin
          if (settle_cnt <= 32'h1) begin
            mode <= pwr_sleep_pkg::st_idle;
          end else begin
            settle_cnt <= settle_cnt - 32'h1;
          end
        end
        pwr_sleep_pkg::st_power_off: begin
          if (shutdown_done) begin
            mode <= pwr_sleep_pkg::st_off;
          end
        end
        pwr_sleep_pkg::st_off: mode <= pwr_sleep_pkg::st_off;
        default: mode <= pwr_sleep_pkg::st_idle;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Outputs are registered from the mode of the previous cycle, one cycle late.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cts_n_out <= 1'b0;
      clocks_run <= 1'b1;
      freeze <= 1'b0;
      power_hold <= 1'b1;
      shutdown <= '0;
    end else begin
      case (mode)
        pwr_sleep_pkg::st_idle: cts_n_out <= 1'b0;
        pwr_sleep_pkg::st_page: cts_n_out <= sleep_cts_block_setting;
        default: cts_n_out <= 1'b1;
      endcase
      clocks_run <= mode != pwr_sleep_pkg::st_sleep;
      freeze <= mode == pwr_sleep_pkg::st_sleep;
      power_hold <= mode != pwr_sleep_pkg::st_off;
      shutdown <= (mode == pwr_sleep_pkg::st_power_off) ? 4'hF : 4'h0;
    end
  end

  // A network event that wakes the device is held while the outputs are frozen.
  // Without it the host would never hear of the event that woke the device.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      event_pend <= 1'b0;
    end else if (mode == pwr_sleep_pkg::st_sleep) begin
      event_pend <= event_pend | net_event;
    end else begin
      event_pend <= 1'b0;
    end
  end
  assign alert_now = net_event | event_pend;

  // Alert to host: outputs hold their levels while frozen.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      host_wake_out <= 1'b0;
      ring_out <= 1'b0;
      serial_alert <= 1'b0;
    end else if (mode != pwr_sleep_pkg::st_sleep) begin
      host_wake_out <= alert_now && alert_sel == pwr_sleep_pkg::alert_wake_out;
      ring_out <= alert_now && alert_sel == pwr_sleep_pkg::alert_ring;
      serial_alert <= alert_now && alert_sel == pwr_sleep_pkg::alert_serial;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  undervolt_off_a: assert property (supply_low |=> mode == pwr_sleep_pkg::st_off)
    else $error("undervoltage did not power off");
  reset_cmd_a: assert property (system_reset_command && !supply_low &&
      mode != pwr_sleep_pkg::st_off |=> mode == pwr_sleep_pkg::st_power_off)
    else $error("reset command ignored");
  no_busy_sleep_a: assert property (busy && mode == pwr_sleep_pkg::st_idle
      |=> mode != pwr_sleep_pkg::st_sleep)
    else $error("slept while busy");
  sleep_cts_a: assert property (mode == pwr_sleep_pkg::st_sleep |=> cts_n_out)
    else $error("cts low in sleep");
  block_page_a: assert property (mode == pwr_sleep_pkg::st_page && sleep_cts_block_setting
      |=> cts_n_out)
    else $error("cts low while blocked");
  page_cts_a: assert property (mode == pwr_sleep_pkg::st_page && !sleep_cts_block_setting
      |=> !cts_n_out)
    else $error("page did not enable cts");
  wake_a: assert property ((!wake_request_in_n && !supply_low && !system_reset_command &&
      key_ms != 16'(KEY_OFF_MS) && mode == pwr_sleep_pkg::st_sleep)
      |=> mode == pwr_sleep_pkg::st_settle)
    else $error("wake input ignored");
  zero_off_a: assert property ((secs_zero_wr && mode == pwr_sleep_pkg::st_idle)
      |=> mode != pwr_sleep_pkg::st_sleep)
    else $error("slept after zero write");
  settle_cts_a: assert property (mode == pwr_sleep_pkg::st_settle |=> cts_n_out)
    else $error("cts low during settling");
  freeze_a: assert property (mode == pwr_sleep_pkg::st_sleep |=>
      $stable({host_wake_out, ring_out, serial_alert}))
    else $error("output moved during sleep");

  sleep_c: cover property (mode == pwr_sleep_pkg::st_sleep);
  page_c: cover property (mode == pwr_sleep_pkg::st_page);
  settle_c: cover property (mode == pwr_sleep_pkg::st_settle ##1 mode == pwr_sleep_pkg::st_idle);
  off_c: cover property (mode == pwr_sleep_pkg::st_power_off ##1 mode == pwr_sleep_pkg::st_off);
  wake_alert_c: cover property (event_pend ##1 (host_wake_out || ring_out || serial_alert));
endmodule : power_sleep_mode_controller

// ### shared/pwr_sleep_cfg.svh
// Timing and setting constants for the power and sleep mode controller.
// Assumes a 200 MHz system clock; included by its bare name.
`ifndef PWR_SLEEP_CFG_SVH
`define PWR_SLEEP_CFG_SVH
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_MHZ 200
`define KEY_OFF_S 3
`define SETTLE_MS 15
`define MS_CYCLES (`CLK_MHZ * 1000)
`define SEC_MS 1000
`define SETTLE_CYCLES (`SETTLE_MS * `MS_CYCLES)
`define PAGE_PERIOD_MS 2000
`define PAGE_AWAKE_MS 10
// ----------------------------------------------------------------------
// Settings
// ----------------------------------------------------------------------
`define SLEEP_SECS_RESET 8'h00
`define CTS_BLOCK_ON 1'b1
`endif

// ### shared/pwr_sleep_pkg.sv
// Types for the power and sleep mode controller.
// Assumes nothing of its surroundings.
package pwr_sleep_pkg;
  typedef enum logic [2:0] {
    st_idle,
    st_sleep,
    st_page,
    st_settle,
    st_power_off,
    st_off
  } mode_t;
  // Activity sources that hold the device awake.
  typedef struct packed {
    logic serial_busy;
    logic net_busy;
    logic task_busy;
  } activity_t;
  // Alert method chosen for incoming network events.
  typedef enum logic [1:0] {
    alert_wake_out,
    alert_serial,
    alert_ring
  } alert_t;
  // Interface disable commands issued during power-off.
  typedef struct packed {
    logic serial_off;
    logic sim_off;
    logic audio_off;
    logic net_close;
  } shutdown_t;
endpackage : pwr_sleep_pkg

// ### verif/host_side_model.sv
// Host-side model: drives the power key and wake request pins of the modem.
// Assumes the bench asks for key presses and wake-ups by level on clk.
`timescale 1ns/1ps
module host_side_model (
  // Clock
  input wire logic clk,
  // Requests from the bench
  input wire logic talk_req,
  input wire logic key_hold,
  // Device pins
  input wire logic cts_n_out,
  output logic wake_request_in_n = 1'b1,
  output logic power_key_n = 1'b1,
  output logic host_ready
);
  // ----------------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------------
  // The key line has a pull-up, so a released key reads high.
  always @(posedge clk) begin
    power_key_n <= !key_hold;
  end
  // The wake pin is used before any traffic, because paging may be blocked.
  always @(posedge clk) begin
    wake_request_in_n <= !talk_req;
  end
  // Settings go out only while the device shows its serial port enabled.
  assign host_ready = talk_req && !wake_request_in_n && !cts_n_out;
endmodule : host_side_model

// ### verif/test_power_sleep_mode_controller.sv
// Self-checking testbench of the power and sleep mode controller.
// Assumes host_side_model and shortened timing parameters.
`timescale 1ns/1ps
module test_power_sleep_mode_controller;
  localparam int MSC = 10;
  localparam int SEC = 1000 * MSC;
  logic clk, nrst = 1'b0, key_hold = 1'b0, talk_req = 1'b0, supply_low = 1'b0;
  logic net_event = 1'b0, shutdown_done = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
  logic power_key_n, wake_request_in_n, host_ready, cts_n_out, host_wake_out, ring_out;
  logic serial_alert, clocks_run, freeze, power_hold;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00, rdata, r;
  logic [7:0] exp_q[$];
  logic [2:0] seen;
  pwr_sleep_pkg::activity_t activity = 3'h0;
  pwr_sleep_pkg::shutdown_t shutdown;
  pwr_sleep_pkg::mode_t mode;
  int error_cnt = 0, checks_done = 0, n, seed;
  power_sleep_mode_controller #(.MS_CYCLES(MSC), .KEY_OFF_MS(5), .SETTLE_MS(2),
    .PAGE_PERIOD_MS(20), .PAGE_AWAKE_MS(3)) dut (.clk, .nrst, .power_key_n,
    .wake_request_in_n, .supply_low, .activity, .net_event, .shutdown_done, .addr,
    .wdata, .wr, .rd, .rdata, .cts_n_out, .host_wake_out, .ring_out, .serial_alert,
    .clocks_run, .freeze, .power_hold, .shutdown, .mode);
  host_side_model host (.clk, .talk_req, .key_hold, .cts_n_out, .wake_request_in_n,
    .power_key_n, .host_ready);
  // ----------------------------------------------------------------------
  // Clock, checks and bus
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic bad(input string m);
    $display("unexpected at %0t: %s", $time, m);
    error_cnt++;
  endtask : bad
  task automatic cmp_mode(input pwr_sleep_pkg::mode_t e);
    checks_done++;
    if (mode !== e) bad("mode differs");
  endtask : cmp_mode
  task automatic cmp_bits(input logic [3:0] g, input logic [3:0] e);
    checks_done++;
    if (g !== e) bad("level differs");
  endtask : cmp_bits
  task automatic cmp_data(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) bad("read data differs");
  endtask : cmp_data
  // Strobes drop for a full cycle, so back-to-back calls never collide.
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg
  task automatic rd_reg(input logic [1:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask : rd_reg
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d === 1'b1 && exp_q.size() > 0) cmp_data(rdata, exp_q.pop_front());
  end
  task automatic wait_mode(input pwr_sleep_pkg::mode_t m, input int lim);
    for (n = 0; n < lim && mode !== m; n++) @(posedge clk);
    if (mode !== m) bad("mode not reached in time");
  endtask : wait_mode
  task automatic pulse_event();
    seen = 3'h0;
    net_event <= 1'b1;
    repeat (4) begin
      @(posedge clk);
      net_event <= 1'b0;
      seen = seen | {host_wake_out, serial_alert, ring_out};
    end
  endtask : pulse_event
  task automatic do_reset();
    nrst <= 1'b0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    cmp_mode(pwr_sleep_pkg::st_idle);
    cmp_bits({cts_n_out, clocks_run, freeze, power_hold}, 4'h5);
  endtask : do_reset
  task automatic conclude();
    $display("errors %0d, checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (90000) @(posedge clk);
    bad("watchdog expired");
    conclude();
  end
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    seed = 32'hbb80;
    do_reset();
    rd_reg(2'h0, 8'h00);
    rd_reg(2'h3, 8'h00);
    r = 8'($random(seed));
    wr_reg(2'h0, r);
    rd_reg(2'h0, r);
    wr_reg(2'h0, 8'h01);
    repeat (SEC + 200) begin
      activity <= 3'($random(seed)) | 3'h1;
      @(posedge clk);
    end
    cmp_mode(pwr_sleep_pkg::st_idle);
    activity <= 3'h0;
    wait_mode(pwr_sleep_pkg::st_sleep, SEC + 200);
    cmp_bits({2'h0, n >= SEC - MSC, n < SEC + 200}, 4'h3);
    repeat (2) @(posedge clk);
    cmp_bits({cts_n_out, clocks_run, freeze, power_hold}, 4'hB);
    rd_reg(2'h2, {4'h0, 1'b1, 3'(pwr_sleep_pkg::st_sleep)});
    wait_mode(pwr_sleep_pkg::st_page, 250);
    repeat (3) @(posedge clk);
    cmp_bits({3'h0, cts_n_out}, 4'h0);
    wr_reg(2'h0, 8'h00);
    wait_mode(pwr_sleep_pkg::st_idle, 40);
    repeat (SEC + 200) @(posedge clk);
    cmp_mode(pwr_sleep_pkg::st_idle);
    wr_reg(2'h0, 8'h01);
    wait_mode(pwr_sleep_pkg::st_sleep, SEC + 200);
    talk_req <= 1'b1;
    for (n = 0; n < 60 && host_ready !== 1'b1; n++) @(posedge clk);
    cmp_bits({2'h0, n >= 2 * MSC, n < 60}, 4'h3);
    repeat (SEC + 200) @(posedge clk);
    cmp_mode(pwr_sleep_pkg::st_idle);
    for (int m = 0; m < 3; m++) begin
      wr_reg(2'h1, 8'(m << 1) | 8'h01);
      pulse_event();
      cmp_bits({1'b0, seen}, {1'b0, 3'h4 >> m});
    end
    rd_reg(2'h1, 8'h05);
    talk_req <= 1'b0;
    wait_mode(pwr_sleep_pkg::st_sleep, SEC + 200);
    wait_mode(pwr_sleep_pkg::st_page, 250);
    repeat (3) @(posedge clk);
    cmp_bits({3'h0, cts_n_out}, 4'h1);
    wait_mode(pwr_sleep_pkg::st_sleep, 60);
    pulse_event();
    cmp_bits({1'b0, seen}, 4'h1);
    wait_mode(pwr_sleep_pkg::st_settle, 5);
    cmp_mode(pwr_sleep_pkg::st_settle);
    wait_mode(pwr_sleep_pkg::st_idle, 40);
    key_hold <= 1'b1;
    wait_mode(pwr_sleep_pkg::st_power_off, 100);
    cmp_bits({2'h0, n >= 4 * MSC, n < 100}, 4'h3);
    repeat (2) @(posedge clk);
    cmp_bits(shutdown, 4'hF);
    key_hold <= 1'b0;
    shutdown_done <= 1'b1;
    wait_mode(pwr_sleep_pkg::st_off, 10);
    repeat (2) @(posedge clk);
    cmp_bits({3'h0, power_hold}, 4'h0);
    shutdown_done <= 1'b0;
    do_reset();
    wr_reg(2'h3, 8'h01);
    wait_mode(pwr_sleep_pkg::st_power_off, 5);
    repeat (2) @(posedge clk);
    cmp_bits(shutdown, 4'hF);
    do_reset();
    supply_low <= 1'b1;
    wait_mode(pwr_sleep_pkg::st_off, 5);
    repeat (2) @(posedge clk);
    cmp_bits({shutdown[0], 2'h0, power_hold}, 4'h0);
    supply_low <= 1'b0;
    do_reset();
    conclude();
  end
endmodule : test_power_sleep_mode_controller
